// [dtod_decoder.sv]
`timescale 1ns/10ps
// How it works
// - 100010dw is register/memory move with modrm
// - 8C with reg msb zero stores segment
// - 8E with reg msb zero loads segment
// - D7 is single-byte table translate
// - 8D loads effective address, not contents
// - C5 loads far pointer with data segment
// - C4 loads far pointer with extra segment
// - 9F/9E/9C/9D flag transfer ops
module dtod_decoder
  import dtod_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 byte_valid,   // Fetch byte strobe
  input  wire logic [7:0]           byte_data,    // Fetched byte
  output logic                      byte_ready,   // Decoder can take byte
  output logic                      dec_valid,    // Result pulse
  output logic                      dec_illegal,  // Not in this group
  output logic [DTOD_NOPS-1:0]      dec_op,       // One-hot class
  output logic                      dec_word,     // Word operation
  output logic                      dec_reg_dest, // Reg field is destination
  output logic [1:0]                dec_mod,      // Mode field
  output logic [2:0]                dec_reg,      // Register field
  output logic [2:0]                dec_rm        // Operand field
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  dtod_state_t             state_r;     // Sequencer
  logic [7:0]              op_r;        // Held first byte
  logic [DTOD_NOPS-1:0]    hit_r;       // Held class
  logic [DTOD_NOPS-1:0]    hit;         // Class of incoming byte
  logic                    need_modrm;  // Two-byte form
  logic                    take;        // Byte accepted
  logic                    seg_bad;     // Segment reg msb set

  dtod_match u_match (
    .op  (byte_data),
    .hit (hit)
  );

  // ----------------------------------------------------------------
  // Handshake and form
  // ----------------------------------------------------------------
  // Single-byte ops finish at once; the rest wait for modrm
  assign need_modrm = hit[OP_MOVE]     | hit[OP_SEGST] | hit[OP_SEGLD] |
                      hit[OP_EFF_ADDR] | hit[OP_FARDS] | hit[OP_FARES];
  // Ready drops in DTOD_DONE, so each result costs one stall cycle
  assign byte_ready = (state_r != DTOD_DONE);
  assign take       = byte_valid & byte_ready;
  assign seg_bad    = byte_data[DTOD_REG_HI];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= DTOD_IDLE;
    end else begin
      case (state_r)
        DTOD_IDLE: begin
          // Opcode byte; two-byte forms fetch modrm next
          if (take && need_modrm) begin
            state_r <= DTOD_ADDR;
          end else if (take) begin
            state_r <= DTOD_DONE;
          end
        end
        DTOD_ADDR: begin
          // Waiting for modrm; idle gaps are allowed here
          if (take) begin
            state_r <= DTOD_DONE;
          end
        end
        // Result on show; one offered byte is refused
        DTOD_DONE: state_r <= DTOD_IDLE;
        // Stray code, recover to idle
        default:   state_r <= DTOD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // First byte capture
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      op_r  <= 8'h00;
      hit_r <= '0;
    end else if (take && state_r == DTOD_IDLE) begin
      op_r  <= byte_data;
      hit_r <= hit;
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dec_valid    <= 1'b0;
      dec_illegal  <= 1'b0;
      dec_op       <= '0;
      dec_word     <= 1'b0;
      dec_reg_dest <= 1'b0;
      dec_mod      <= 2'h0;
      dec_reg      <= 3'h0;
      dec_rm       <= 3'h0;
    end else begin
      dec_valid <= 1'b0;
      if (take && state_r == DTOD_IDLE && !need_modrm) begin
        // One-byte form, or unknown byte
        dec_valid    <= 1'b1;
        dec_op       <= hit;
        dec_illegal  <= ~|hit;
        dec_word     <= 1'b0;
        dec_reg_dest <= 1'b0;
        dec_mod      <= 2'h0;
        dec_reg      <= 3'h0;
        dec_rm       <= 3'h0;
      end else if (take && state_r == DTOD_ADDR) begin
        dec_valid <= 1'b1;
        dec_op    <= hit_r;
        // Segment forms only allow four registers
        dec_illegal <= (hit_r[OP_SEGST] | hit_r[OP_SEGLD]) & seg_bad;
        // Moves honour w and d; pointer and seg ops are word
        dec_word <= hit_r[OP_MOVE] ? op_r[DTOD_W_BIT] : 1'b1;
        dec_reg_dest <= hit_r[OP_MOVE] ? op_r[DTOD_D_BIT] :
                        ~hit_r[OP_SEGST];
        dec_mod <= byte_data[DTOD_MOD_HI:DTOD_MOD_LO];
        dec_reg <= byte_data[DTOD_REG_HI:DTOD_REG_LO];
        dec_rm  <= byte_data[DTOD_RM_HI:DTOD_RM_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_MOVE: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && byte_data[7:2] == DTOD_MOVE_RM_PFX)
    ##1 (byte_valid && byte_ready) |=> (dec_valid && dec_op[OP_MOVE]))
    else $error("move not decoded");
  AST_SEGST: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && byte_data == DTOD_SEG_STORE)
    ##1 (take && !byte_data[DTOD_REG_HI]) |=>
    (dec_op[OP_SEGST] && !dec_illegal && !dec_reg_dest))
    else $error("segment store wrong");
  AST_SEGLD: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && byte_data == DTOD_SEG_LOAD)
    ##1 (take && byte_data[DTOD_REG_HI]) |=> (dec_valid && dec_illegal))
    else $error("bad segment not flagged");
  AST_TRANSLATE: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && byte_data == DTOD_XLATE) |=>
    (dec_valid && dec_op[OP_TRANSLATE] && state_r == DTOD_DONE))
    else $error("translate not single byte");
  AST_EFF_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && byte_data == DTOD_EFF_ADDR) |=>
    (state_r == DTOD_ADDR && !dec_valid))
    else $error("effective address lacks modrm");
  AST_FAR: assert property (@(posedge clock) disable iff (!rst_n)
    (dec_valid && (dec_op[OP_FARDS] || dec_op[OP_FARES])) |->
    (dec_word && dec_reg_dest && $past(state_r) == DTOD_ADDR))
    else $error("far pointer decode wrong");
  AST_FARES: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && byte_data == DTOD_FAR_EXTRA)
    ##1 take |=> dec_op[OP_FARES] && !dec_op[OP_FARDS])
    else $error("extra segment pointer wrong");
  AST_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && byte_data == DTOD_POP_FLAGS) |=>
    (dec_valid && dec_op[OP_POP_FL] && !dec_illegal))
    else $error("pop flags not decoded");
  AST_FIELDS: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_ADDR) |=>
    ({dec_mod, dec_reg, dec_rm} == $past(byte_data)))
    else $error("modrm fields misplaced");
  AST_WIDTH: assert property (@(posedge clock) disable iff (!rst_n)
    (dec_valid && dec_op[OP_MOVE]) |-> (dec_word == op_r[DTOD_W_BIT]))
    else $error("width bit ignored");

  // ----------------------------------------------------------------
  // Checks on operand forms
  // ----------------------------------------------------------------
  // Direction bit picks which side the register field names
  AST_DIRECTION: assert property (@(posedge clock) disable iff (!rst_n)
    (dec_valid && dec_op[OP_MOVE]) |-> (dec_reg_dest == op_r[DTOD_D_BIT]))
    else $error("direction bit ignored");
  // Legal segment load writes a segment register from the operand
  AST_SEGLD_OK: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && byte_data == DTOD_SEG_LOAD)
    ##1 (take && !byte_data[DTOD_REG_HI]) |=>
    (dec_valid && dec_op[OP_SEGLD] && !dec_illegal && dec_reg_dest))
    else $error("segment load wrong");
  // Only four segment registers exist, so a set msb is refused
  AST_SEGST_BAD: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && byte_data == DTOD_SEG_STORE)
    ##1 (take && byte_data[DTOD_REG_HI]) |=>
    (dec_valid && dec_op[OP_SEGST] && dec_illegal))
    else $error("bad segment store not flagged");
  // Effective address goes to the register, never from it
  AST_EFF_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && byte_data == DTOD_EFF_ADDR)
    ##1 take |=>
    (dec_valid && dec_op[OP_EFF_ADDR] && dec_reg_dest && dec_word))
    else $error("effective address load wrong");
  // Data segment pointer load must not pass as the extra one
  AST_FAR_DATA: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && byte_data == DTOD_FAR_DATA)
    ##1 take |=> (dec_valid && dec_op[OP_FARDS] && !dec_op[OP_FARES]))
    else $error("data segment pointer wrong");
  // One-byte forms carry no operand fields; stale modrm is cleared
  AST_ONE_BYTE: assert property (@(posedge clock) disable iff (!rst_n)
    (take && state_r == DTOD_IDLE && !need_modrm) |=>
    (dec_valid && !dec_word && !dec_reg_dest &&
     dec_mod == 2'h0 && dec_reg == 3'h0 && dec_rm == 3'h0))
    else $error("one-byte form left fields set");

endmodule : dtod_decoder

// [dtod_match.sv]
`timescale 1ns/10ps
// Pure first-byte classifier, registered nowhere
module dtod_match
  import dtod_pkg::*;
(
  input  wire logic [7:0]           op,
  output logic [DTOD_NOPS-1:0]      hit
);

  // ----------------------------------------------------------------
  // Pattern table
  // ----------------------------------------------------------------
  always_comb begin
    hit                = '0;
    hit[OP_MOVE]       = (op[7:2] == DTOD_MOVE_RM_PFX);
    hit[OP_SEGST]      = (op == DTOD_SEG_STORE);
    hit[OP_SEGLD]      = (op == DTOD_SEG_LOAD);
    hit[OP_TRANSLATE]  = (op == DTOD_XLATE);
    hit[OP_EFF_ADDR]   = (op == DTOD_EFF_ADDR);
    hit[OP_FARDS]      = (op == DTOD_FAR_DATA);
    hit[OP_FARES]      = (op == DTOD_FAR_EXTRA);
    hit[OP_FLAGS_HI]   = (op == DTOD_FLAGS_TO_HI);
    hit[OP_HI_FLAGS]   = (op == DTOD_HI_TO_FLAGS);
    hit[OP_PUSH_FL]    = (op == DTOD_PUSH_FLAGS);
    hit[OP_POP_FL]     = (op == DTOD_POP_FLAGS);
  end

endmodule : dtod_match

// [dtod_pkg.sv]
package dtod_pkg;

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [5:0] DTOD_MOVE_RM_PFX   = 6'h22;  // 100010dw
  localparam logic [7:0] DTOD_SEG_STORE     = 8'h8c;
  localparam logic [7:0] DTOD_SEG_LOAD      = 8'h8e;
  localparam logic [7:0] DTOD_EFF_ADDR      = 8'h8d;
  localparam logic [7:0] DTOD_FAR_DATA      = 8'hc5;
  localparam logic [7:0] DTOD_FAR_EXTRA     = 8'hc4;
  localparam logic [7:0] DTOD_XLATE         = 8'hd7;
  localparam logic [7:0] DTOD_FLAGS_TO_HI   = 8'h9f;
  localparam logic [7:0] DTOD_HI_TO_FLAGS   = 8'h9e;
  localparam logic [7:0] DTOD_PUSH_FLAGS    = 8'h9c;
  localparam logic [7:0] DTOD_POP_FLAGS     = 8'h9d;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DTOD_W_BIT    = 0;
  localparam int DTOD_D_BIT    = 1;
  localparam int DTOD_MOD_HI   = 7;
  localparam int DTOD_MOD_LO   = 6;
  localparam int DTOD_REG_HI   = 5;
  localparam int DTOD_REG_LO   = 3;
  localparam int DTOD_RM_HI    = 2;
  localparam int DTOD_RM_LO    = 0;

  // Operation classes, one-hot index order
  localparam int DTOD_NOPS = 11;
  localparam int OP_MOVE   = 0;
  localparam int OP_SEGST  = 1;
  localparam int OP_SEGLD  = 2;
  localparam int OP_TRANSLATE = 3;
  localparam int OP_EFF_ADDR  = 4;
  localparam int OP_FARDS     = 5;
  localparam int OP_FARES     = 6;
  localparam int OP_FLAGS_HI  = 7;
  localparam int OP_HI_FLAGS  = 8;
  localparam int OP_PUSH_FL   = 9;
  localparam int OP_POP_FL    = 10;

  // Decoder states
  typedef enum logic [2:0] {
    DTOD_IDLE = 3'b001,
    DTOD_ADDR = 3'b010,
    DTOD_DONE = 3'b100
  } dtod_state_t;

endpackage : dtod_pkg

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import dtod_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic                 clock;        // 125 MHz bench clock
  logic                 rst_n;        // Synchronous reset
  logic                 byte_valid;   // Byte offered
  logic [7:0]           byte_data;    // Byte value
  logic                 byte_ready;   // Decoder accepts
  logic                 dec_valid;    // Result strobe
  logic                 dec_illegal;  // Outside group
  logic [DTOD_NOPS-1:0] dec_op;       // One-hot class
  logic                 dec_word;     // Word width
  logic                 dec_reg_dest; // Direction
  logic [1:0]           dec_mod;      // Mode field
  logic [2:0]           dec_reg;      // Register field
  logic [2:0]           dec_rm;       // Operand field
  int                   error_cnt;    // Mismatches
  int                   cmp_count;    // Comparisons

  dtod_decoder dut (.clock(clock), .rst_n(rst_n), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .dec_valid(dec_valid),
    .dec_illegal(dec_illegal), .dec_op(dec_op), .dec_word(dec_word),
    .dec_reg_dest(dec_reg_dest), .dec_mod(dec_mod), .dec_reg(dec_reg),
    .dec_rm(dec_rm));

  // Free-running clock, 8 ns period
  always #4 clock = ~clock;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Single exit point for the whole run
  task end_sim;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // Four-state compare, so an unknown never matches
  task chk(input string name, input logic [10:0] exp, input logic [10:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", name, exp, got);
    end
  endtask : chk

  // Offer one byte, hold it until an edge sees ready high
  task put(input logic [7:0] b);
    int n;
    n = 0;
    byte_valid <= 1'b1;
    byte_data  <= b;
    @(negedge clock);
    while (byte_ready !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk("byte_ready", 11'h1, byte_ready);
        end_sim();
      end
      @(negedge clock);
    end
    @(posedge clock);
  endtask : put

  // Full instruction with optional addressing byte and idle gap
  task run(input logic [7:0] op, input logic two, input logic [7:0] m,
           input int gap, input int cls, input logic w, input logic d);
    logic [7:0] f;
    f = two ? m : 8'h00;
    put(op);
    if (two) begin
      if (gap > 0) begin
        byte_valid <= 1'b0;
        repeat (gap) @(posedge clock);
      end
      put(m);
    end
    byte_valid <= 1'b0;
    #1;
    chk("dec_valid", 11'h1, dec_valid);
    chk("byte_ready", 11'h0, byte_ready);
    chk("dec_op", 11'h1 << cls, dec_op);
    chk("dec_illegal", 11'h0, dec_illegal);
    chk("dec_word", w, dec_word);
    chk("dec_reg_dest", d, dec_reg_dest);
    chk("dec_mod", f[7:6], dec_mod);
    chk("dec_reg", f[5:3], dec_reg);
    chk("dec_rm", f[2:0], dec_rm);
    @(posedge clock);
    #1;
    chk("dec_valid", 11'h0, dec_valid);
    chk("byte_ready", 11'h1, byte_ready);
    @(posedge clock);
  endtask : run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] mtab [4];
    mtab = '{8'hc1, 8'h3a, 8'h85, 8'h5f};
    clock = 1'b0; rst_n = 1'b0; byte_valid = 1'b0; byte_data = 8'h00;
    error_cnt = 0; cmp_count = 0;
    repeat (12) @(posedge clock);
    #1;
    chk("reset dec_valid", 11'h0, dec_valid);
    chk("reset dec_op", 11'h0, dec_op);
    chk("reset byte_ready", 11'h1, byte_ready);
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    // All four direction and width forms, one with a gap
    for (int i = 0; i < 4; i++) begin
      run({DTOD_MOVE_RM_PFX, i[1:0]}, 1'b1, mtab[i], (i == 2) ? 3 : 0,
          OP_MOVE, i[0], i[1]);
    end
    run(DTOD_SEG_STORE, 1'b1, 8'h1e, 0, OP_SEGST, 1'b1, 1'b0);
    run(DTOD_SEG_LOAD, 1'b1, 8'hd8, 0, OP_SEGLD, 1'b1, 1'b1);
    run(DTOD_XLATE, 1'b0, 8'h00, 0, OP_TRANSLATE, 1'b0, 1'b0);
    run(DTOD_EFF_ADDR, 1'b1, 8'h46, 0, OP_EFF_ADDR, 1'b1, 1'b1);
    run(DTOD_FAR_DATA, 1'b1, 8'h36, 0, OP_FARDS, 1'b1, 1'b1);
    run(DTOD_FAR_EXTRA, 1'b1, 8'h1f, 0, OP_FARES, 1'b1, 1'b1);
    run(DTOD_FLAGS_TO_HI, 1'b0, 8'h00, 0, OP_FLAGS_HI, 1'b0, 1'b0);
    run(DTOD_HI_TO_FLAGS, 1'b0, 8'h00, 0, OP_HI_FLAGS, 1'b0, 1'b0);
    // Back to back: second byte held through the refused cycle
    put(DTOD_PUSH_FLAGS);
    byte_data <= DTOD_POP_FLAGS;
    #1;
    chk("dec_op push", 11'h1 << OP_PUSH_FL, dec_op);
    @(posedge clock);
    #1;
    chk("dec_valid refused", 11'h0, dec_valid);
    @(posedge clock);
    byte_valid <= 1'b0;
    #1;
    chk("dec_valid pop", 11'h1, dec_valid);
    chk("dec_op pop", 11'h1 << OP_POP_FL, dec_op);
    repeat (2) @(posedge clock);
    // Segment forms with high register bit, then a foreign byte
    put(DTOD_SEG_STORE);
    put(8'h26);
    byte_valid <= 1'b0;
    #1;
    chk("seg illegal", 11'h1, dec_illegal);
    chk("seg store op", 11'h1 << OP_SEGST, dec_op);
    repeat (2) @(posedge clock);
    put(DTOD_SEG_LOAD);
    put(8'h2e);
    byte_valid <= 1'b0;
    #1;
    chk("seg load valid", 11'h1, dec_valid);
    chk("seg load illegal", 11'h1, dec_illegal);
    repeat (2) @(posedge clock);
    put(8'h90);
    byte_valid <= 1'b0;
    #1;
    chk("foreign valid", 11'h1, dec_valid);
    chk("foreign illegal", 11'h1, dec_illegal);
    repeat (2) @(posedge clock);
    run(DTOD_XLATE, 1'b0, 8'h00, 0, OP_TRANSLATE, 1'b0, 1'b0);
    end_sim();
  end
endmodule : tb_top
